// ==== src/spm_pkg.sv ====
// Constants for SPI ports 0 and 1: register indices, field positions, reset values, states.
// Assumes each byte-wide register sits in the low byte of one aligned 32-bit bus word.
`default_nettype none

package spm_pkg;

  localparam logic [7:0] CTL0_IDX = 8'hB6;
  localparam logic [7:0] FLG0_IDX = 8'hB7;
  localparam logic [7:0] DAT0_IDX = 8'hB8;
  localparam logic [7:0] CTL1_IDX = 8'hBA;
  localparam logic [7:0] FLG1_IDX = 8'hBB;
  localparam logic [7:0] DAT1_IDX = 8'hBC;

  localparam int IE_BIT   = 7;
  localparam int EN_BIT   = 5;
  localparam int MS_BIT   = 4;
  localparam int CLOCK_IDLE_LEVEL_BIT = 3;
  localparam int CLOCK_PHASE_SELECT_BIT = 2;
  localparam int DONE_BIT = 7;
  localparam int WRITE_COLLISION_FLAG_BIT = 6;
  localparam int MODE_FAULT_FLAG_BIT = 4;

  localparam logic [7:0] CTL_RST   = 8'h04;
  localparam logic [7:0] CTL_WMASK = 8'hBC;
  localparam logic [3:0] LAST_CNT  = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_HOLD = 2'b10
  } spm_state_type;

endpackage

`default_nettype wire

// ==== src/spm_sck_if.sv ====
// Link between the port engine and its master SCK generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface spm_sck_if;
  logic run;
  logic clock_idle_level;
  logic lead;
  logic trail;
  logic sck;

  modport gen (input run, input clock_idle_level, output lead, output trail, output sck);
  modport eng (output run, output clock_idle_level, input lead, input trail, input sck);
endinterface

`default_nettype wire

// ==== src/spm_sck_gen.sv ====
// Master SCK generator: halves the baud-rate tick into SCK and edge pulses.
// Assumes tick_i is a one-cycle enable pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none

module spm_sck_gen
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  spm_sck_if.gen    sif
);

  typedef struct packed {
    logic armed;
    logic phase;
    logic lead;
    logic trail;
  } spm_gen_state_type;

  spm_gen_state_type q;
  spm_gen_state_type n;

  always_comb
  begin
    n = q;
    n.lead = 1'b0;
    n.trail = 1'b0;
    if (!sif.run)
    begin
      n.armed = 1'b0;
      n.phase = 1'b0;
    end
    else if (tick_i)
    begin
      // First tick only arms, giving the first data bit half a period of setup
      if (!q.armed)
        n.armed = 1'b1;
      else
      begin
        n.phase = !q.phase;
        n.lead = !q.phase;
        n.trail = q.phase;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end

  assign sif.lead = q.lead;
  assign sif.trail = q.trail;
  assign sif.sck = sif.clock_idle_level ^ q.phase;

  property p_tick_paced;
    @(posedge clk_i) disable iff (rst_i)
    $changed(q.phase) && q.phase |-> $past(tick_i) && $past(q.armed);
  endproperty
  a_tick_paced: assert property (p_tick_paced)
    else $error("SCK moved without a baud tick");

endmodule // spm_sck_gen

`default_nettype wire

// ==== src/spm_port.sv ====
// One SPI port, master or slave, with its registers on a classic Wishbone slave.
// Assumes pin inputs are synchronous to clk_i and brg_tick_i comes from a baud generator.
`timescale 1ns/1ps
`default_nettype none

module spm_port
#(
  parameter int ADDR_W  = 10,
  parameter int PORT_ID = 0
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              brg_tick_i,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe_o,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_o,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  input  wire logic              ss_n_i,
  output logic                   irq_o
);

  if (ADDR_W < 10 || PORT_ID < 0 || PORT_ID > 1)
  begin : g_bad_param
    $error("spm_port needs ADDR_W of 10 or more and PORT_ID of 0 or 1");
  end

  localparam logic [7:0] CTL_I = (PORT_ID == 0) ? spm_pkg::CTL0_IDX : spm_pkg::CTL1_IDX;
  localparam logic [7:0] FLG_I = (PORT_ID == 0) ? spm_pkg::FLG0_IDX : spm_pkg::FLG1_IDX;
  localparam logic [7:0] DAT_I = (PORT_ID == 0) ? spm_pkg::DAT0_IDX : spm_pkg::DAT1_IDX;
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({CTL_I, 2'b00});
  localparam logic [ADDR_W-1:0] A_FLG = ADDR_W'({FLG_I, 2'b00});
  localparam logic [ADDR_W-1:0] A_DAT = ADDR_W'({DAT_I, 2'b00});

  typedef struct packed {
    spm_pkg::spm_state_type state;
    logic [7:0]             ctl;
    logic                   transfer_done_flag;
    logic                   write_collision_flag;
    logic                   mode_fault_flag;
    logic [7:0]             sh;
    logic [7:0]             rxb;
    logic [3:0]             cnt;
    logic                   latch;
    logic                   dout;
    logic                   sck_q;
    logic                   ss_q;
    logic                   ack;
    logic [31:0]            dat;
  } spm_port_state_type;

  localparam spm_port_state_type Q_RST = '{
    state: spm_pkg::ST_IDLE,
    ctl:   spm_pkg::CTL_RST,
    transfer_done_flag:  1'b0,
    write_collision_flag:  1'b0,
    mode_fault_flag:  1'b0,
    sh:    8'h00,
    rxb:   8'h00,
    cnt:   4'h0,
    latch: 1'b0,
    dout:  1'b0,
    sck_q: 1'b0,
    ss_q:  1'b1,
    ack:   1'b0,
    dat:   32'h0000_0000
  };

  spm_port_state_type q;
  spm_port_state_type n;

  spm_sck_if sif ();

  logic       req;
  logic       wr_ok;
  logic       enabled;
  logic       master;
  logic       slave;
  logic       clock_idle_level;
  logic       clock_phase_select;
  logic       lead;
  logic       trail;
  logic       rx_in;
  logic       act;
  logic       done_c;
  logic [7:0] flags;

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr_ok = wb_we_i && wb_sel_i[0];
  assign enabled = q.ctl[spm_pkg::EN_BIT];
  assign master = enabled && q.ctl[spm_pkg::MS_BIT];
  assign slave = enabled && !q.ctl[spm_pkg::MS_BIT];
  assign clock_idle_level = q.ctl[spm_pkg::CLOCK_IDLE_LEVEL_BIT];
  assign clock_phase_select = q.ctl[spm_pkg::CLOCK_PHASE_SELECT_BIT];

  spm_sck_gen u_gen
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (brg_tick_i),
    .sif    (sif)
  );

  // Drop run on the last trailing pulse so a fast tick cannot add a seventeenth SCK edge
  assign sif.run = master && (q.state == spm_pkg::ST_XFER)
                   && !(sif.trail && q.cnt == spm_pkg::LAST_CNT);
  assign sif.clock_idle_level = clock_idle_level;

  always_comb
  begin
    n = q;
    done_c = 1'b0;
    act = 1'b0;
    flags = 8'h00;
    flags[spm_pkg::DONE_BIT] = q.transfer_done_flag;
    flags[spm_pkg::WRITE_COLLISION_FLAG_BIT] = q.write_collision_flag;
    flags[spm_pkg::MODE_FAULT_FLAG_BIT] = q.mode_fault_flag;
    n.ack = req;
    n.sck_q = sck_i;
    n.ss_q = ss_n_i;

    // Unmapped addresses answer with zero and ignore writes
    if (req)
    begin
      n.dat = 32'h0000_0000;
      if (wb_adr_i == A_CTL)
      begin
        if (wb_we_i)
        begin
          if (wb_sel_i[0])
            n.ctl = wb_dat_i[7:0] & spm_pkg::CTL_WMASK;
        end
        else
          n.dat[7:0] = q.ctl;
      end
      else if (wb_adr_i == A_FLG)
      begin
        if (!wb_we_i)
        begin
          n.dat[7:0] = flags;
          n.transfer_done_flag = 1'b0;
          n.write_collision_flag = 1'b0;
          n.mode_fault_flag = 1'b0;
        end
      end
      else if (wb_adr_i == A_DAT)
      begin
        if (wr_ok && q.state == spm_pkg::ST_XFER)
          n.write_collision_flag = 1'b1;
        else if (wr_ok)
        begin
          n.sh = wb_dat_i[7:0];
          n.dout = wb_dat_i[7];
          if (master)
            n.state = spm_pkg::ST_XFER;
        end
        else if (!wb_we_i)
          n.dat[7:0] = q.rxb;
      end
    end

    // Slave edges are taken from the sampled pin; master edges from the generator
    lead = master ? sif.lead
                  : slave && !ss_n_i && (q.sck_q == clock_idle_level) && (sck_i != clock_idle_level);
    trail = master ? sif.trail
                   : slave && !ss_n_i && (q.sck_q != clock_idle_level) && (sck_i == clock_idle_level);
    rx_in = master ? miso_i : mosi_i;
    act = (q.state == spm_pkg::ST_XFER);

    if (slave && q.state == spm_pkg::ST_IDLE && !ss_n_i)
    begin
      if (!clock_phase_select && q.ss_q)
      begin
        n.state = spm_pkg::ST_XFER;
        n.dout = q.sh[7];
      end
      else if (clock_phase_select && lead)
      begin
        n.state = spm_pkg::ST_XFER;
        act = 1'b1;
      end
    end

    if (act && lead)
    begin
      if (!clock_phase_select)
        n.latch = rx_in;
      else
        n.dout = q.sh[7];
    end

    if (act && trail)
    begin
      n.sh = {q.sh[6:0], clock_phase_select ? rx_in : q.latch};
      if (!clock_phase_select)
        n.dout = q.sh[6];
      n.cnt = q.cnt + 4'h1;
      if (q.cnt == spm_pkg::LAST_CNT)
      begin
        done_c = 1'b1;
        n.cnt = 4'h0;
        // Phase 0 slave must see SS rise before another byte can start
        n.state = (slave && !clock_phase_select) ? spm_pkg::ST_HOLD : spm_pkg::ST_IDLE;
      end
    end

    // A flag still set means software missed the last byte, so this one is dropped
    if (done_c)
    begin
      if (!n.transfer_done_flag)
        n.rxb = n.sh;
      n.transfer_done_flag = 1'b1;
    end

    if (slave && ss_n_i && q.state != spm_pkg::ST_IDLE)
    begin
      n.state = spm_pkg::ST_IDLE;
      n.cnt = 4'h0;
    end

    if (!enabled)
    begin
      n.state = spm_pkg::ST_IDLE;
      n.cnt = 4'h0;
    end

    if (master && !ss_n_i)
    begin
      n.mode_fault_flag = 1'b1;
      n.ctl[spm_pkg::EN_BIT] = 1'b0;
      n.ctl[spm_pkg::MS_BIT] = 1'b0;
      n.state = spm_pkg::ST_IDLE;
      n.cnt = 4'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= Q_RST;
    else
      q <= n;
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign sck_o = sif.sck;
  assign sck_oe_o = master;
  assign mosi_o = q.dout;
  assign mosi_oe_o = master;
  assign miso_o = q.dout;
  assign miso_oe_o = slave && !ss_n_i;
  assign irq_o = q.ctl[spm_pkg::IE_BIT] && (q.transfer_done_flag || q.mode_fault_flag);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_write_collision_flag_busy;
    req && wr_ok && wb_adr_i == A_DAT && q.state == spm_pkg::ST_XFER && !done_c
      && (master ? ss_n_i : (slave && !ss_n_i))
      |=> q.write_collision_flag && q.state == spm_pkg::ST_XFER;
  endproperty
  a_write_collision_flag_busy: assert property (p_write_collision_flag_busy)
    else $error("Collision write not flagged or transfer disturbed");

  property p_done_sets;
    done_c |=> q.transfer_done_flag ##1 $stable(q.rxb) || q.transfer_done_flag;
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("Completed byte did not set the done flag");

  property p_mode_fault_flag;
    master && !ss_n_i |=> q.mode_fault_flag && !q.ctl[spm_pkg::EN_BIT] && !q.ctl[spm_pkg::MS_BIT]
      && !mosi_oe_o;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag)
    else $error("Mode fault not handled");

  property p_flag_clear;
    req && !wb_we_i && wb_adr_i == A_FLG && !done_c && !(master && !ss_n_i)
      |=> !q.transfer_done_flag && !q.write_collision_flag && !q.mode_fault_flag && wb_ack_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Status read did not clear flags");

  property p_irq_gate;
    !q.ctl[spm_pkg::IE_BIT] |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt raised while disabled");

  property p_sck_idle;
    master && q.state != spm_pkg::ST_XFER |-> sck_o == clock_idle_level;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("Master SCK not at idle level");

  property p_released;
    !enabled |-> !miso_oe_o && !mosi_oe_o && !sck_oe_o;
  endproperty
  a_released: assert property (p_released)
    else $error("Pin driven while port disabled");

  property p_rx_read;
    req && !wb_we_i && wb_adr_i == A_DAT
      |=> wb_ack_o && wb_dat_o == {24'h000000, $past(q.rxb)} ##1 !wb_ack_o;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("Data read did not return the receive buffer");

  property p_overrun;
    done_c && q.transfer_done_flag && !req |=> $stable(q.rxb);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("Overrun byte overwrote the receive buffer");

  property p_eight_edges;
    master && q.state == spm_pkg::ST_XFER && sif.trail && q.cnt == spm_pkg::LAST_CNT
      |=> q.transfer_done_flag && q.state == spm_pkg::ST_IDLE && sck_o == clock_idle_level;
  endproperty
  a_eight_edges: assert property (p_eight_edges)
    else $error("Master byte did not end after eight SCK cycles");

  property p_master_start;
    master && req && wr_ok && wb_adr_i == A_DAT && q.state == spm_pkg::ST_IDLE && ss_n_i
      |=> q.state == spm_pkg::ST_XFER && q.sh == $past(wb_dat_i[7:0]) && q.cnt == 4'h0;
  endproperty
  a_master_start: assert property (p_master_start)
    else $error("Master write did not start a transfer");

endmodule // spm_port

`default_nettype wire

// ==== testbench/spm_peer.sv ====
// Peer SPI slave that faces the port when the port runs in master role.
// Assumes SCK and MOSI arrive from the port's registered outputs on clk_i.
`timescale 1ns/1ps
`default_nettype none

module spm_peer
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_i,
  input  wire logic       clock_idle_level_i,
  input  wire logic       clock_phase_select_i,
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic sck_reg;
  logic miso_reg;
  logic moved;
  logic lead;

  assign moved  = (sck_i !== sck_reg);
  assign lead   = (sck_i !== clock_idle_level_i);
  // A released line shows the inverse of its last level, so stale data cannot pass
  assign miso_o = sel_i ? miso_reg : ~miso_reg;

  always_ff @(posedge clk_i)
  begin
    sck_reg <= sck_i;
    if (rst_i)
    begin
      miso_reg <= 1'b0;
      rx_o     <= 8'h00;
    end
    else if (load_i)
    begin
      rx_o     <= byte_i;
      miso_reg <= byte_i[7];
    end
    else if (sel_i && moved && (lead ^ clock_phase_select_i))
      rx_o <= {rx_o[6:0], mosi_i};
    else if (sel_i && moved)
      miso_reg <= rx_o[7];
  end
endmodule // spm_peer

`default_nettype wire

// ==== testbench/test_spi_master_slave_port.sv ====
// Self-checking bench for one SPI port: registers, master and slave bytes, faults.
// Assumes PORT_ID 0 placement and the peer slave model on the serial lines.
`timescale 1ns/1ps
`default_nettype none

module test_spi_master_slave_port;
  localparam int LIMIT = 20000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic        tick = 1'b0;
  logic [1:0]  tcnt = 2'h0;
  logic        sck_s = 1'b0;
  logic        mosi_s = 1'b0;
  logic        ss_n = 1'b1;
  logic        p_sel = 1'b0;
  logic        p_load = 1'b0;
  logic [7:0]  p_byte = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        sck_q = 1'b0;
  logic [31:0] rdat;
  logic        ack, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, irq_o, miso_p;
  logic [7:0]  p_rx, q, tx, px, t2, p2, got;
  integer      seed = 32'haf9b;
  integer      err_total = 0;
  integer      n_tests = 0;
  integer      cycles = 0;
  integer      edges = 0;

  spm_port #(.ADDR_W(10), .PORT_ID(0)) spm_port_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .brg_tick_i(tick), .sck_i(sck_s), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_i(mosi_s), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_p),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n), .irq_o(irq_o)
  );

  spm_peer spm_peer_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_o), .mosi_i(mosi_o), .sel_i(p_sel),
    .clock_idle_level_i(mode[1]), .clock_phase_select_i(mode[0]), .load_i(p_load), .byte_i(p_byte),
    .miso_o(miso_p), .rx_o(p_rx)
  );

  always #25 clk_i = ~clk_i;

  // Baud tick every fourth clock keeps each SCK half period at four clocks
  always @(posedge clk_i)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    sck_q <= sck_o;
    if (sck_o !== sck_q)
      edges = edges + 1;
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'h1;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(q, e);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic start(input logic [7:0] t, input logic [7:0] r);
    @(posedge clk_i);
    p_byte <= r;
    p_load <= 1'b1;
    p_sel  <= 1'b1;
    @(posedge clk_i);
    p_load <= 1'b0;
    edges = 0;
    wb(1'b1, spm_pkg::DAT0_IDX, t);
  endtask

  // md[1] is the SCK idle level, md[0] the clock phase
  task automatic slave_xfer(input logic [1:0] md, input logic [7:0] b);
    @(posedge clk_i);
    sck_s  <= md[1];
    @(posedge clk_i);
    ss_n   <= 1'b0;
    mosi_s <= b[7];
    repeat (4) @(posedge clk_i);
    chk({7'h00, miso_oe_o}, 8'h01);
    for (int i = 7; i >= 0; i--)
    begin
      if (!md[0])
        got[i] = miso_o;
      sck_s <= ~md[1];
      if (md[0])
        mosi_s <= b[i];
      repeat (4) @(posedge clk_i);
      if (md[0])
        got[i] = miso_o;
      sck_s <= md[1];
      if (i > 0 && !md[0])
        mosi_s <= b[i-1];
      repeat (4) @(posedge clk_i);
    end
    ss_n   <= 1'b1;
    mosi_s <= ~mosi_s;
    repeat (3) @(posedge clk_i);
    chk({7'h00, miso_oe_o}, 8'h00);
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(spm_pkg::CTL0_IDX, spm_pkg::CTL_RST);
    rd(spm_pkg::FLG0_IDX, 8'h00);
    rd(8'h10, 8'h00);
    wb(1'b1, spm_pkg::CTL0_IDX, 8'h43);
    rd(spm_pkg::CTL0_IDX, 8'h00);
    chk({5'h00, sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      mode = m[1:0];
      tx = 8'($random(seed));
      px = 8'($random(seed));
      wb(1'b1, spm_pkg::CTL0_IDX, 8'hB0 | {4'h0, mode, 2'b00});
      start(tx, px);
      if (m == 3)
        wb(1'b1, spm_pkg::DAT0_IDX, ~tx);
      wait_irq();
      chk({6'h00, irq_o, sck_o}, {6'h00, 1'b1, mode[1]});
      chk(edges[7:0], 8'h10);
      rd(spm_pkg::FLG0_IDX, (m == 3) ? 8'hC0 : 8'h80);
      chk({7'h00, irq_o}, 8'h00);
      rd(spm_pkg::DAT0_IDX, px);
      chk(p_rx, tx);
    end
    mode = 2'h0;
    t2 = 8'h5A;
    p2 = 8'hC3;
    wb(1'b1, spm_pkg::CTL0_IDX, 8'hB0);
    start(8'hA5, 8'h3C);
    wait_irq();
    start(t2, p2);
    repeat (90) @(posedge clk_i);
    rd(spm_pkg::FLG0_IDX, 8'h80);
    rd(spm_pkg::DAT0_IDX, 8'h3C);
    chk(p_rx, t2);
    p_sel <= 1'b0;
    ss_n  <= 1'b0;
    wait_irq();
    chk({7'h00, irq_o}, 8'h01);
    ss_n <= 1'b1;
    rd(spm_pkg::FLG0_IDX, 8'h10);
    rd(spm_pkg::CTL0_IDX, 8'h80);
    chk({7'h00, sck_oe_o}, 8'h00);
    // Slave in phase 0 with low idle, then phase 1 with high idle
    for (int s = 0; s < 2; s++)
    begin
      wb(1'b1, spm_pkg::CTL0_IDX, (s == 0) ? 8'h20 : 8'h2C);
      tx = 8'($random(seed));
      px = 8'($random(seed));
      wb(1'b1, spm_pkg::DAT0_IDX, tx);
      slave_xfer({s[0], s[0]}, px);
      chk(got, tx);
      chk({7'h00, irq_o}, 8'h00);
      rd(spm_pkg::FLG0_IDX, 8'h80);
      rd(spm_pkg::DAT0_IDX, px);
    end
    conclude();
  end
endmodule // test_spi_master_slave_port

`default_nettype wire
